// ### design/bbc_pkg.sv
// package for the block byte compare sequencer
// assumes a single cpu clock domain; shared by the sequencer and its bench
package bbc_pkg;
  localparam int PTR_W = 24;
  localparam int CNT_W = 8;
  localparam int DATA_W = 8;
  localparam logic [PTR_W-1:0] PTR_RST = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_STEP = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
  // flag vector bit positions
  localparam int FLAG_SIGN = 4;
  localparam int FLAG_ZERO = 3;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_OVF = 1;
  localparam int FLAG_BORROW = 0;
  localparam int FLAG_W = 5;
  localparam logic [FLAG_W-1:0] FLAG_RST = 5'h00;

  // which size condition ends the loop
  typedef enum logic {
    BBC_UNTIL_LESS,
    BBC_UNTIL_NOT_LESS
  } bbc_variant_t;
endpackage

// ### design/bbc_block_byte_compare_sequencer.sv
// block byte compare sequencer: reads two byte blocks, compares, sets flags
// assumes a read-only data memory port with request/valid handshake and a
// cpu core that supplies pointers, count and suspend requests on clk_sys
//
// Behaviour
// - each step computes first-block byte minus second-block byte and the until-less variant stops on borrow or zero count.
// - the until-not-less variant repeats until no borrow occurs or the count reaches zero.
// - after each step both 24-bit pointers move by one, up for post-increment and down for post-decrement.
// - after each step the byte count is decremented by one.
// - each step works on single bytes fetched from the two locations.
// - the block only reads memory and never writes either block.
// - a pending interrupt or macro service request suspends the loop between steps and is acknowledged.
// - on suspend the pointers and count are presented for saving and a resume continues from them.
// - after a macro service transfer completes the loop continues automatically.
// - the five flags reflect only the last subtraction performed.
// - the sign flag copies bit 7 of the result.
// - the zero flag is set when the 8-bit result is zero.
// - the half borrow flag is set on a borrow from bit 4 into bit 3.
// - the overflow flag is set when exactly one of the bit 6 and bit 7 borrows occurs.
// - the borrow flag is set on a borrow out of bit 7 and drives termination.
`timescale 1ns/10ps
module bbc_block_byte_compare_sequencer
  import bbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  // start or resume; pointers and count are loaded with it
  input wire logic start,
  input wire bbc_pkg::bbc_variant_t variant,
  input wire logic postDecrement,
  input wire logic [bbc_pkg::PTR_W-1:0] firstBlockPointerIn,
  input wire logic [bbc_pkg::PTR_W-1:0] secondBlockPointerIn,
  input wire logic [bbc_pkg::CNT_W-1:0] countIn,
  // suspend requests and macro service completion from the interrupt controller
  input wire logic interruptReq,
  input wire logic macroServiceReq,
  input wire logic macroServiceDone,
  // data memory read port
  output logic memReadReq,
  output logic [bbc_pkg::PTR_W-1:0] memAddr,
  output logic memWriteEn,
  input wire logic memReadValid,
  input wire logic [bbc_pkg::DATA_W-1:0] memReadData,
  // state to the core
  output logic busy,
  output logic done,
  output logic interruptAck,
  output logic macroServiceAck,
  output logic [bbc_pkg::PTR_W-1:0] firstBlockPointer,
  output logic [bbc_pkg::PTR_W-1:0] secondBlockPointer,
  output logic [bbc_pkg::CNT_W-1:0] saved_count_byte,
  output logic [bbc_pkg::FLAG_W-1:0] flags
);
  import bbc_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (PTR_W != 24 || CNT_W != 8 || DATA_W != 8) begin : g_check
    $error("bbc: pointer, count and data widths are fixed at 24/8/8");
  end

  // ----------------------------------------------------------------
  // flag calculation
  // ----------------------------------------------------------------
  // flags of a - b in the bit order of the flag vector
  // a ^ b ^ result is the borrow coming into each bit; the extra top bit
  // is the borrow out of bit 7, which the loop end test also reads
  function automatic logic [FLAG_W-1:0] calcFlags(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    logic [DATA_W:0] diff;
    logic [DATA_W-1:0] res;
    logic [DATA_W:0] brw;
    logic [FLAG_W-1:0] f;
    diff = {1'b0, a} - {1'b0, b};
    res = diff[DATA_W-1:0];
    // borrow into each bit position: a ^ b ^ result gives the chain
    brw = {diff[DATA_W], a ^ b ^ res};
    f = FLAG_RST;
    f[FLAG_SIGN] = res[7];
    f[FLAG_ZERO] = (res == DATA_RST);
    f[FLAG_HALF] = brw[4];
    f[FLAG_OVF] = brw[7] ^ brw[8];
    f[FLAG_BORROW] = brw[8];
    return f;
  endfunction

  function automatic logic [PTR_W-1:0] stepPtr(
    input logic [PTR_W-1:0] p,
    input logic down
  );
    return down ? p - PTR_STEP : p + PTR_STEP;
  endfunction

  // end test after one step: the count is tested after its decrement, so a
  // count of zero on entry wraps and allows up to 256 steps
  function automatic logic stopAfter(
    input bbc_variant_t v,
    input logic borrow,
    input logic [CNT_W-1:0] cntAfter
  );
    logic sizeHit;
    // until-less ends on a borrow, until-not-less once no borrow is left
    sizeHit = (v == BBC_UNTIL_LESS) ? borrow : !borrow;
    return sizeHit || (cntAfter == CNT_RST);
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ_FIRST,
    ST_READ_SECOND,
    ST_EXEC,
    ST_MACRO
  } bbc_state_t;

  bbc_state_t state_reg, state_next;
  bbc_variant_t variant_reg, variant_next;
  logic down_reg, down_next;
  logic [PTR_W-1:0] first_reg, first_next;
  logic [PTR_W-1:0] second_reg, second_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic [DATA_W-1:0] byteA_reg, byteA_next;
  logic [DATA_W-1:0] byteB_reg, byteB_next;
  logic [FLAG_W-1:0] flags_reg, flags_next;
  logic req_reg, req_next;
  logic [PTR_W-1:0] addr_reg, addr_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic intAck_reg, intAck_next;
  logic msAck_reg, msAck_next;
  logic wrEn_reg, wrEn_next;

  // ----------------------------------------------------------------
  // one compare step
  // ----------------------------------------------------------------
  // the flags are worked out every cycle but only kept in the exec state
  logic [FLAG_W-1:0] stepFlags;
  logic [CNT_W-1:0] countDec;
  logic endLoop;

  always_comb begin
    stepFlags = calcFlags(byteA_reg, byteB_reg);
    countDec = count_reg - CNT_STEP;
    endLoop = stopAfter(variant_reg, stepFlags[FLAG_BORROW],
      countDec);
  end

  always_comb begin
    state_next = state_reg;
    variant_next = variant_reg;
    down_next = down_reg;
    first_next = first_reg;
    second_next = second_reg;
    count_next = count_reg;
    byteA_next = byteA_reg;
    byteB_next = byteB_reg;
    flags_next = flags_reg;
    req_next = 1'b0;
    addr_next = addr_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    intAck_next = 1'b0;
    msAck_next = 1'b0;
    wrEn_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // start is only looked at here; a start while busy is dropped
        if (start) begin
          // a resume reloads the saved pointers and count
          variant_next = variant;
          down_next = postDecrement;
          first_next = firstBlockPointerIn;
          second_next = secondBlockPointerIn;
          count_next = countIn;
          req_next = 1'b1;
          addr_next = firstBlockPointerIn;
          busy_next = 1'b1;
          state_next = ST_READ_FIRST;
        end
      end
      ST_READ_FIRST: begin
        // request and address stand until the memory answers
        req_next = 1'b1;
        if (memReadValid) begin
          byteA_next = memReadData;
          addr_next = second_reg;
          state_next = ST_READ_SECOND;
        end
      end
      ST_READ_SECOND: begin
        req_next = 1'b1;
        if (memReadValid) begin
          byteB_next = memReadData;
          // the port goes quiet for the exec cycle so that no read is wasted
          req_next = 1'b0;
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // only the step that is kept updates the flags
        flags_next = stepFlags;
        first_next = stepPtr(first_reg, down_reg);
        second_next = stepPtr(second_reg, down_reg);
        count_next = countDec;
        // ending outranks both suspends; an interrupt outranks macro service
        if (endLoop) begin
          busy_next = 1'b0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end else if (interruptReq) begin
          // suspend between steps; core saves pointers and count outputs
          intAck_next = 1'b1;
          busy_next = 1'b0;
          state_next = ST_IDLE;
        end else if (macroServiceReq) begin
          msAck_next = 1'b1;
          state_next = ST_MACRO;
        end else begin
          req_next = 1'b1;
          addr_next = stepPtr(first_reg, down_reg);
          state_next = ST_READ_FIRST;
        end
      end
      ST_MACRO: begin
        // the loop state is held untouched while the transfer runs
        if (macroServiceDone) begin
          req_next = 1'b1;
          addr_next = first_reg;
          state_next = ST_READ_FIRST;
        end
      end
      default: begin
        state_next = ST_IDLE;
        busy_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // synchronous reset; every register takes a constant so that the
  // outputs are all low from the first edge of reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      variant_reg <= BBC_UNTIL_LESS;
      down_reg <= 1'b0;
      first_reg <= PTR_RST;
      second_reg <= PTR_RST;
      count_reg <= CNT_RST;
      byteA_reg <= DATA_RST;
      byteB_reg <= DATA_RST;
      flags_reg <= FLAG_RST;
      req_reg <= 1'b0;
      addr_reg <= PTR_RST;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      intAck_reg <= 1'b0;
      msAck_reg <= 1'b0;
      wrEn_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      variant_reg <= variant_next;
      down_reg <= down_next;
      first_reg <= first_next;
      second_reg <= second_next;
      count_reg <= count_next;
      byteA_reg <= byteA_next;
      byteB_reg <= byteB_next;
      flags_reg <= flags_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      intAck_reg <= intAck_next;
      msAck_reg <= msAck_next;
      wrEn_reg <= wrEn_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign memReadReq = req_reg;
  assign memAddr = addr_reg;
  // the write strobe exists for the shared port; it is held low from a flop
  assign memWriteEn = wrEn_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign interruptAck = intAck_reg;
  assign macroServiceAck = msAck_reg;
  // pointers and count double as the image saved on a suspend
  assign firstBlockPointer = first_reg;
  assign secondBlockPointer = second_reg;
  assign saved_count_byte = count_reg;
  assign flags = flags_reg;
endmodule

// ### verification/bbc_seq_props.sv
// checker for the block compare sequencer: timing and flag relations
// assumes it is bound to the sequencer and sees only its ports
`timescale 1ns/10ps
module bbc_seq_props
  import bbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic interruptAck,
  input wire logic macroServiceAck,
  input wire logic macroServiceDone,
  input wire logic memReadReq,
  input wire logic [bbc_pkg::PTR_W-1:0] memAddr,
  input wire logic memWriteEn,
  input wire logic [bbc_pkg::PTR_W-1:0] firstBlockPointer,
  input wire logic [bbc_pkg::PTR_W-1:0] secondBlockPointer,
  input wire logic [bbc_pkg::CNT_W-1:0] saved_count_byte,
  input wire logic [bbc_pkg::FLAG_W-1:0] flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  no_write_a: assert property (memWriteEn == 1'b0)
    else $error("memory write seen");
  addr_first_a: assert property (
    $rose(memReadReq) |-> memAddr == firstBlockPointer)
    else $error("first read not at first pointer");
  addr_second_a: assert property (
    memReadReq && $past(memReadReq) && $changed(memAddr) |->
    memAddr == secondBlockPointer)
    else $error("second read not at second pointer");
  start_read_a: assert property (start && !busy |=> busy && memReadReq)
    else $error("no read after start");
  exec_gap_a: assert property (done |->
    !busy && !$past(memReadReq) && $past(memReadReq, 2))
    else $error("done without read and exec");
  irq_idle_a: assert property (interruptAck |-> !busy && !done)
    else $error("busy at interrupt ack");
  msr_resume_a: assert property (
    busy && !memReadReq && macroServiceDone |=> memReadReq)
    else $error("no resume after macro service");
  count_dec_a: assert property (
    $changed(saved_count_byte) && $past(busy) |->
    saved_count_byte == $past(saved_count_byte) - 8'h01)
    else $error("count not decremented by one");
  ptr_move_a: assert property (
    $changed(firstBlockPointer) && $past(busy) |->
    firstBlockPointer - $past(firstBlockPointer) ==
    secondBlockPointer - $past(secondBlockPointer) &&
    firstBlockPointer - $past(firstBlockPointer) inside {24'h1, 24'hffffff})
    else $error("pointers moved apart");
  flag_hold_a: assert property ($changed(flags) |-> $past(busy))
    else $error("flags changed while idle");
  zero_flag_a: assert property (
    flags[FLAG_ZERO] |-> (flags & 5'h17) == 5'h00)
    else $error("zero result with other flags");
  cover property (done && flags[FLAG_ZERO]);
  cover property (interruptAck);
  cover property (macroServiceAck);
endmodule
bind bbc_block_byte_compare_sequencer bbc_seq_props u_props (.clk_sys,
  .rst_n, .start, .busy, .done, .interruptAck, .macroServiceAck,
  .macroServiceDone, .memReadReq, .memAddr, .memWriteEn, .firstBlockPointer,
  .secondBlockPointer, .saved_count_byte, .flags);

// ### verification/bbc_mem_model.sv
// read-only data memory: a byte reads back as the low byte of its address
// assumes the sequencer holds request and address until valid is seen
`timescale 1ns/10ps
module bbc_mem_model
  import bbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [1:0] lag,
  input wire logic memReadReq,
  input wire logic [bbc_pkg::PTR_W-1:0] memAddr,
  output logic memReadValid,
  output logic [bbc_pkg::DATA_W-1:0] memReadData
);
  logic [1:0] waitReg = 2'h0;
  logic [DATA_W-1:0] lastReg = 8'h5a;
  assign memReadValid = memReadReq && waitReg >= lag;
  // inverted stale byte so a late sample never looks right by chance
  assign memReadData = memReadValid ? memAddr[7:0] : ~lastReg;
  always_ff @(posedge clk_sys) begin
    waitReg <= (!memReadReq || memReadValid) ? 2'h0 : waitReg + 2'h1;
    if (memReadValid) begin
      lastReg <= memAddr[7:0];
    end
  end
endmodule

// ### verification/tb.sv
// self-checking bench for the block compare sequencer
// assumes the memory model returns the low address byte as data
`timescale 1ns/10ps
module tb;
  import bbc_pkg::*;
  logic clk_sys, rst_n, start, postDecrement, interruptReq;
  logic macroServiceReq, macroServiceDone, memReadReq, memWriteEn;
  logic memReadValid, busy, done, interruptAck, macroServiceAck;
  bbc_variant_t variant;
  logic [PTR_W-1:0] firstBlockPointerIn, secondBlockPointerIn, memAddr;
  logic [PTR_W-1:0] firstBlockPointer, secondBlockPointer;
  logic [CNT_W-1:0] countIn, saved_count_byte;
  logic [DATA_W-1:0] memReadData;
  logic [FLAG_W-1:0] flags;
  logic [1:0] lag;
  int failures, total_checks, acks;
  bbc_block_byte_compare_sequencer dut (.clk_sys, .rst_n, .start, .variant,
    .postDecrement, .firstBlockPointerIn, .secondBlockPointerIn, .countIn,
    .interruptReq, .macroServiceReq, .macroServiceDone, .memReadReq,
    .memAddr, .memWriteEn, .memReadValid, .memReadData, .busy, .done,
    .interruptAck, .macroServiceAck, .firstBlockPointer,
    .secondBlockPointer, .saved_count_byte, .flags);
  bbc_mem_model mem (.clk_sys, .lag, .memReadReq, .memAddr, .memReadValid,
    .memReadData);
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task complete_run;
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  function automatic logic [4:0] flg(input logic [7:0] a, b);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] l;
    r = {1'b0, a} - {1'b0, b};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    l = {1'b0, a[6:0]} - {1'b0, b[6:0]};
    return {r[7], r[7:0] == 8'h00, h[4], l[7] ^ r[8], r[8]};
  endfunction
  // runs one instruction to its end, serving suspends on the way
  task automatic run(input bbc_variant_t v, input logic d,
      input logic [23:0] p1, p2, input logic [7:0] c);
    logic [23:0] a, b;
    logic [7:0] n;
    logic [4:0] f;
    a = p1;
    b = p2;
    n = c;
    do begin
      f = flg(a[7:0], b[7:0]);
      a = d ? a - PTR_STEP : a + PTR_STEP;
      b = d ? b - PTR_STEP : b + PTR_STEP;
      n = n - CNT_STEP;
    end while (n != 8'h00 && f[0] == (v == BBC_UNTIL_NOT_LESS));
    @(posedge clk_sys);
    variant <= v;
    {postDecrement, countIn, start} <= {d, c, 1'b1};
    {firstBlockPointerIn, secondBlockPointerIn} <= {p1, p2};
    @(posedge clk_sys);
    start <= 1'b0;
    for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(negedge clk_sys);
      if (interruptAck === 1'b1) begin
        acks++;
        chk(busy === 1'b0, "busy at interrupt ack");
        @(posedge clk_sys);
        {interruptReq, start, countIn} <= {1'b0, 1'b1, saved_count_byte};
        firstBlockPointerIn <= firstBlockPointer;
        secondBlockPointerIn <= secondBlockPointer;
        @(posedge clk_sys);
        start <= 1'b0;
      end
      if (macroServiceAck === 1'b1) begin
        acks++;
        @(posedge clk_sys);
        {macroServiceReq, macroServiceDone} <= 2'b01;
        @(posedge clk_sys);
        macroServiceDone <= 1'b0;
      end
    end
    if (done !== 1'b1) begin
      chk(1'b0, "no end of loop within bound");
      complete_run();
    end else begin
      chk(firstBlockPointer === a && secondBlockPointer === b, "ptr");
      chk(saved_count_byte === n, "count");
      chk(flags === f, "flags");
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task sc_basic;
    run(BBC_UNTIL_LESS, 1'b0, 24'h000010, 24'h000005, 8'h03);
    run(BBC_UNTIL_LESS, 1'b1, 24'h120020, 24'h340022, 8'h05);
    run(BBC_UNTIL_NOT_LESS, 1'b0, 24'h000030, 24'h000030, 8'h09);
    run(BBC_UNTIL_NOT_LESS, 1'b1, 24'h000005, 24'h000010, 8'h04);
  endtask
  task sc_flags;
    run(BBC_UNTIL_LESS, 1'b0, 24'h000080, 24'h000001, 8'h01);
    run(BBC_UNTIL_LESS, 1'b0, 24'h000100, 24'h000080, 8'h01);
    run(BBC_UNTIL_LESS, 1'b0, 24'h000013, 24'h000024, 8'h01);
  endtask
  task sc_suspend;
    acks = 0;
    @(posedge clk_sys);
    interruptReq <= 1'b1;
    run(BBC_UNTIL_LESS, 1'b0, 24'h000040, 24'h000020, 8'h04);
    @(posedge clk_sys);
    lag <= 2'h2;
    macroServiceReq <= 1'b1;
    run(BBC_UNTIL_NOT_LESS, 1'b1, 24'h000002, 24'h000050, 8'h03);
    chk(acks == 2, "suspend count");
  endtask
  task sc_wrap;
    @(posedge clk_sys);
    lag <= 2'h1;
    run(BBC_UNTIL_LESS, 1'b0, 24'h000100, 24'h000200, 8'h00);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, start, postDecrement, interruptReq} = 4'h0;
    {macroServiceReq, macroServiceDone, lag, countIn} = 12'h000;
    {firstBlockPointerIn, secondBlockPointerIn} = 48'h0;
    variant = BBC_UNTIL_LESS;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    sc_basic();
    sc_flags();
    sc_suspend();
    sc_wrap();
    complete_run();
  end
endmodule
